//--- pkg/frame_seq_params.svh
`ifndef FRAME_SEQ_PARAMS_SVH
`define FRAME_SEQ_PARAMS_SVH

// core clock and link clock rates
`define CLK_HZ 10_000_000
`define LINK_HZ 83_333_333
`define SER_CLK_HZ 50_000
`define SER_HALF_CYC ((`LINK_HZ) / (2 * (`SER_CLK_HZ)))

// word and frame layout
`define WORD_BITS 10
`define SAMPLES_PER_FRAME 1708
`define HK_PER_FRAME 25
`define FRINGES_PER_SAMPLE 4

// timing, each figure in its own unit and then in core cycles
`define COLLECT_S 10
`define COLLECT_CYC ((`COLLECT_S) * (`CLK_HZ))
`define EOF_PULSE_US 100
`define EOF_PULSE_CYC (((`EOF_PULSE_US) * (`CLK_HZ)) / 1_000_000)
`define RT_PULSE_US 10
`define RT_PULSE_CYC (((`RT_PULSE_US) * (`CLK_HZ)) / 1_000_000)

`endif

//--- pkg/frame_seq_pkg.sv
`include "frame_seq_params.svh"

package frame_seq_pkg;

  typedef logic [`WORD_BITS-1:0] data_word_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_COLLECT = 3'b001,
    ST_HOUSEKEEP = 3'b010,
    ST_DRAIN = 3'b011,
    ST_END = 3'b100
  } frame_state_t;

  // input synchronisers of the core domain: stage 1, stage 2, edge history; ack has the two stages only
  typedef struct packed {
    logic [2:0] init;
    logic [2:0] fringe;
    logic [2:0] tick400;
    logic [2:0] thermal;
    logic [1:0] ack;
  } core_sync_t;

  typedef struct packed {
    core_sync_t sync;
    frame_state_t state;
    logic [1:0] fringe_cnt;
    logic [10:0] sample_cnt;
    logic [4:0] hk_cnt;
    logic [26:0] timer;
    logic [9:0] eof_cnt;
    logic [6:0] rt_cnt;
    logic eof_out;
    logic rt_out;
    logic mirror_park;
    logic mirror_scan;
    logic busy;
    logic overrun;
    logic push_valid;
    data_word_t push_word;
    logic req_tog;
    logic pending;
    data_word_t hold_word;
  } core_state_t;

  typedef struct packed {
    logic [1:0] req;
    logic ack_tog;
    logic [9:0] div_cnt;
    logic ser_clk;
    logic ser_data;
    logic active;
    logic [3:0] bits_left;
    data_word_t shift;
  } link_state_t;

  typedef struct packed {
    data_word_t [1:0] slot;
    logic rd;
    logic wr;
    logic [1:0] count;
  } buf_state_t;

endpackage : frame_seq_pkg

//--- logic/word_buffer.sv
`timescale 1ns/100ps

// two-entry word buffer; a full buffer drops in_ready so the writer stalls
module word_buffer (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  input wire frame_seq_pkg::data_word_t in_word,
  output logic in_ready,
  output logic out_valid,
  output frame_seq_pkg::data_word_t out_word,
  input wire logic out_ready
);
  import frame_seq_pkg::*;

  buf_state_t st;
  buf_state_t next_st;
  logic push;
  logic pop;

  // flags come straight from the occupancy count
  assign in_ready = (st.count != 2'h2);
  assign out_valid = (st.count != 2'h0);
  assign out_word = st.slot[st.rd];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.slot[st.wr] = in_word;
      next_st.wr = ~st.wr;
    end
    if (pop) begin
      next_st.rd = ~st.rd;
    end
    if (push && !pop) begin
      next_st.count = st.count + 2'h1;
    end else if (pop && !push) begin
      next_st.count = st.count - 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : word_buffer

//--- logic/interferogram_frame_sequencer.sv
`timescale 1ns/100ps
`include "frame_seq_params.svh"

// Overview of operation
// - instrument emits its own end-of-frame pulse
// - 400 cps pulse clock crosses the interface
// - instrument drives a 50 kc clock out
// - data leaves as 10-bit words, one high
// - thermal/visible event gives a 10 us pulse
// - each acquisition spans 10 seconds
// - sample on every fourth reference fringe
// - frame holds 1708 samples plus 25 housekeeping
// - idle instrument parks mirror at neutral midrange
module interferogram_frame_sequencer #(
  parameter logic [26:0] COLLECT_CYC = 27'(`COLLECT_CYC)
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic frame_init,
  input wire logic fringe,
  input wire logic tick400,
  input wire logic thermal_evt,
  input wire frame_seq_pkg::data_word_t sample_word,
  input wire frame_seq_pkg::data_word_t hk_word,
  output logic [4:0] hk_sel,
  output logic eof_pulse,
  output logic rt_pulse,
  output logic ser_clk,
  output logic ser_data,
  output logic ser_word_active,
  output logic mirror_park,
  output logic mirror_scan,
  output logic frame_busy,
  output logic overrun
);
  import frame_seq_pkg::*;

  // a frame is a fixed-length word stream: the sample words of one collection,
  // zero words for any sample the fringe train failed to deliver, then the
  // housekeeping words. the receiving end can therefore count words rather
  // than look for markers, at the cost of padding a short or stalled scan.
  // the collection window is timed by the core clock alone; the fringe train
  // only decides when samples are taken inside it.

  // frame layout and pulse widths, each sized to the counter that holds it
  localparam logic [10:0] SAMPLES = 11'(`SAMPLES_PER_FRAME);
  localparam logic [4:0] HK_WORDS = 5'(`HK_PER_FRAME);
  localparam logic [1:0] LAST_FRINGE = 2'(`FRINGES_PER_SAMPLE - 1);
  localparam logic [9:0] EOF_CYC = 10'(`EOF_PULSE_CYC);
  localparam logic [6:0] RT_CYC = 7'(`RT_PULSE_CYC);
  localparam logic [9:0] SER_HALF = 10'(`SER_HALF_CYC);
  localparam logic [3:0] BITS = 4'(`WORD_BITS);

  // core and link state, one struct per clock domain
  core_state_t cs;
  core_state_t next_cs;
  link_state_t ls;
  link_state_t next_ls;

  // word buffer handshakes on the core side
  logic buf_in_ready;
  logic buf_out_valid;
  data_word_t buf_out_word;
  logic buf_out_ready;

  // strobes and handshake status decoded from the synchronisers
  logic init_rise;
  logic fringe_rise;
  logic tick_rise;
  logic thermal_rise;
  logic ack_seen;

  // edge detects read only the second and third stages, never the first,
  // so a pin that changes inside the setup window cannot reach the sequencing
  function automatic logic rise_of(input logic [2:0] hist);
    return hist[1] & ~hist[2];
  endfunction : rise_of

  // one-cycle strobes from the synchronised pins
  assign init_rise = rise_of(cs.sync.init);
  assign fringe_rise = rise_of(cs.sync.fringe);
  assign tick_rise = rise_of(cs.sync.tick400);
  assign thermal_rise = rise_of(cs.sync.thermal);
  assign ack_seen = (cs.sync.ack[1] == cs.req_tog);

  // the crossing takes a word only while no handshake is outstanding
  // a toggle request carries the word to the link clock: hold_word stays
  // frozen from the toggle until the answering toggle is back through two
  // flops, so the link can load all ten bits without a gray code. one word
  // in flight costs a gap between words, which the slow link hides anyway.
  assign buf_out_ready = ~cs.pending;

  // two entries absorb the handshake gap, so a sample taken while the link
  // is busy waits here instead of being lost
  word_buffer u_word_buffer (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(cs.push_valid),
    .in_word(cs.push_word),
    .in_ready(buf_in_ready),
    .out_valid(buf_out_valid),
    .out_word(buf_out_word),
    .out_ready(buf_out_ready)
  );

  // core domain: frame sequencing, sampling and the sending side of the crossing
  // every async pin enters through a three-stage history: two flops to settle
  // it and a third that only serves the edge detect
  always_comb begin
    next_cs = cs;
    next_cs.sync.init = {cs.sync.init[1:0], frame_init};
    next_cs.sync.fringe = {cs.sync.fringe[1:0], fringe};
    next_cs.sync.tick400 = {cs.sync.tick400[1:0], tick400};
    next_cs.sync.thermal = {cs.sync.thermal[1:0], thermal_evt};
    next_cs.sync.ack = {cs.sync.ack[0], ls.ack_tog};

    // a word taken by the buffer frees the push register
    if (cs.push_valid && buf_in_ready) begin
      next_cs.push_valid = 1'b0;
    end

    // hand the buffer head to the link; word is held until acknowledged
    if (cs.pending && ack_seen) begin
      next_cs.pending = 1'b0;
    end else if (!cs.pending && buf_out_valid) begin
      next_cs.hold_word = buf_out_word;
      next_cs.req_tog = ~cs.req_tog;
      next_cs.pending = 1'b1;
    end

    // real-time channel pulse, retriggered by each new event
    // a burst of events stretches one pulse rather than running pulses together
    if (thermal_rise) begin
      next_cs.rt_out = 1'b1;
      next_cs.rt_cnt = RT_CYC - 7'h1;
    end else if (cs.rt_cnt != 7'h0) begin
      next_cs.rt_cnt = cs.rt_cnt - 7'h1;
    end else begin
      next_cs.rt_out = 1'b0;
    end

    case (cs.state)
      ST_IDLE: begin
        // an initiate is only honoured here, so a busy frame ignores it
        if (init_rise) begin
          next_cs.state = ST_COLLECT;
          next_cs.timer = 27'h0;
          next_cs.fringe_cnt = 2'h0;
          next_cs.sample_cnt = 11'h0;
          next_cs.hk_cnt = 5'h0;
          next_cs.overrun = 1'b0;
          next_cs.mirror_park = 1'b0;
          next_cs.mirror_scan = 1'b1;
          next_cs.busy = 1'b1;
        end
      end
      ST_COLLECT: begin
        // fixed collection window regardless of how many fringes arrive
        // the mirror returns to neutral on the edge that closes the window
        if (cs.timer == COLLECT_CYC - 27'h1) begin
          next_cs.state = ST_HOUSEKEEP;
          next_cs.mirror_scan = 1'b0;
          next_cs.mirror_park = 1'b1;
        end else begin
          next_cs.timer = cs.timer + 27'h1;
        end
        if (fringe_rise) begin
          next_cs.fringe_cnt = cs.fringe_cnt + 2'h1;
          // one sample per fourth fringe, up to the frame's sample count
          if (cs.fringe_cnt == LAST_FRINGE && cs.sample_cnt != SAMPLES) begin
            // the fringe train cannot be paused, so a sample that finds the push
            // register still full is dropped and flagged rather than stalling
            if (next_cs.push_valid) begin
              next_cs.overrun = 1'b1; // buffer still full: the sample is lost
            end else begin
              next_cs.push_valid = 1'b1;
              next_cs.push_word = sample_word;
              next_cs.sample_cnt = cs.sample_cnt + 11'h1;
            end
          end
        end
      end
      ST_HOUSEKEEP: begin
        // short collections are padded with zero words so frames keep their length
        // a stalled buffer simply holds this state; padding and housekeeping
        // wait for room rather than drop words, so only samples can be lost
        if (!next_cs.push_valid) begin
          if (cs.sample_cnt != SAMPLES) begin
            next_cs.push_valid = 1'b1;
            next_cs.push_word = '0;
            next_cs.sample_cnt = cs.sample_cnt + 11'h1;
          end else if (cs.hk_cnt == HK_WORDS) begin
            next_cs.state = ST_DRAIN;
          end else if (tick_rise) begin
            // housekeeping words are paced by the 400 cps clock
            next_cs.push_valid = 1'b1;
            next_cs.push_word = hk_word;
            next_cs.hk_cnt = cs.hk_cnt + 5'h1;
          end
        end
      end
      ST_DRAIN: begin
        // end of frame only after the last bit has left the link
        // so the pulse tells the receiver that the frame is complete on the wire
        if (!cs.push_valid && !buf_out_valid && !cs.pending) begin
          next_cs.state = ST_END;
          next_cs.eof_out = 1'b1;
          next_cs.eof_cnt = EOF_CYC - 10'h1;
        end
      end
      ST_END: begin
        // busy drops with the pulse, so no initiate is honoured during it
        if (cs.eof_cnt != 10'h0) begin
          next_cs.eof_cnt = cs.eof_cnt - 10'h1;
        end else begin
          next_cs.eof_out = 1'b0;
          next_cs.busy = 1'b0;
          next_cs.state = ST_IDLE;
        end
      end
      default: begin
        next_cs.state = ST_IDLE;
      end
    endcase
  end

  // the mirror comes out of reset parked; every other core flop starts at zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs <= '0;
      cs.mirror_park <= 1'b1; // neutral position from power-up
    end else begin
      cs <= next_cs;
    end
  end

  // link domain: free-running serial clock and word shifter
  // the 50 kc clock runs whether or not a word is moving, so the receiver
  // can stay locked between words; ser_word_active marks the bit cells.
  // the divider truncates the half period to whole link cycles, so the real
  // rate sits a fraction of a percent above nominal.
  // between words ser_data rests low, which reads as zeros to a receiver
  // that ignores the active line.
  always_comb begin
    next_ls = ls;
    next_ls.req = {ls.req[0], cs.req_tog};

    // serial clock divided down from the link clock; it never stops
    if (ls.div_cnt == SER_HALF - 10'h1) begin
      next_ls.div_cnt = 10'h0;
      next_ls.ser_clk = ~ls.ser_clk;
      // data changes on the falling edge so it is steady at the rising one
      if (ls.ser_clk) begin
        if (ls.bits_left != 4'h0) begin
          next_ls.ser_data = ls.shift[`WORD_BITS-1];
          next_ls.shift = {ls.shift[`WORD_BITS-2:0], 1'b0};
          next_ls.bits_left = ls.bits_left - 4'h1;
        end else if (ls.active) begin
          next_ls.active = 1'b0;
          next_ls.ack_tog = ~ls.ack_tog;
          next_ls.ser_data = 1'b0;
        end
      end
    end else begin
      next_ls.div_cnt = ls.div_cnt + 10'h1;
    end

    // hold_word is stable while the request toggle is unanswered
    // a load never meets a bit in progress: it waits for active to drop,
    // and the first bit then waits for the next falling edge of ser_clk
    if (!ls.active && (ls.req[1] != ls.ack_tog)) begin
      next_ls.shift = cs.hold_word;
      next_ls.bits_left = BITS;
      next_ls.active = 1'b1;
    end
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      ls <= '0;
    end else begin
      ls <= next_ls;
    end
  end

  // outputs come straight from state flops
  // frame_busy has its own flop so that it spans housekeeping and drain,
  // where neither the scan nor the park line tells a frame apart from idle
  assign hk_sel = cs.hk_cnt;
  assign eof_pulse = cs.eof_out;
  assign rt_pulse = cs.rt_out;
  assign ser_clk = ls.ser_clk;
  assign ser_data = ls.ser_data;
  assign ser_word_active = ls.active;
  assign mirror_park = cs.mirror_park;
  assign mirror_scan = cs.mirror_scan;
  assign frame_busy = cs.busy;
  assign overrun = cs.overrun;

endmodule : interferogram_frame_sequencer

//--- tb/frame_seq_assertions.sv
`timescale 1ns/100ps
module frame_seq_checker #(
  parameter logic [26:0] COLLECT_CYC = 27'h5f5e100
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic thermal_evt,
  input wire logic eof_pulse,
  input wire logic rt_pulse,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_word_active,
  input wire logic mirror_park,
  input wire logic mirror_scan,
  input wire logic frame_busy
);
  logic [26:0] scan_len;
  logic [9:0] eof_len;
  logic [7:0] rt_len;
  logic [9:0] half_len;
  logic last_clk;
  logic clk_seen;
  // high-time counters; rt saturates so a retriggered pulse cannot wrap
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scan_len <= '0;
      eof_len <= '0;
      rt_len <= '0;
    end else begin
      scan_len <= mirror_scan ? scan_len + 27'h1 : '0;
      eof_len <= eof_pulse ? eof_len + 10'h1 : '0;
      rt_len <= rt_pulse ? rt_len + {7'h0, rt_len != 8'hff} : '0;
    end
  end
  // first toggle after reset is partial, so only later halves are judged
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      last_clk <= 1'b0;
      clk_seen <= 1'b0;
      half_len <= '0;
    end else if (ser_clk != last_clk) begin
      last_clk <= ser_clk;
      clk_seen <= 1'b1;
      half_len <= '0;
    end else begin
      half_len <= half_len + 10'h1;
    end
  end
  sequence s_therm;
    $rose(thermal_evt);
  endsequence
  sequence s_rt_ans;
    ##[1:6] rt_pulse;
  endsequence
  property p_scan_len;
    @(posedge clk) disable iff (!rst_b) $fell(mirror_scan) |-> scan_len == COLLECT_CYC;
  endproperty
  a_scan_len: assert property (p_scan_len) else $error("scan length");
  property p_eof_len;
    @(posedge clk) disable iff (!rst_b) $fell(eof_pulse) |-> eof_len == 10'h3e8;
  endproperty
  a_eof_len: assert property (p_eof_len) else $error("eof width");
  property p_busy_end;
    @(posedge clk) disable iff (!rst_b) $fell(frame_busy) |-> $past(eof_pulse) || $past(eof_pulse, 2);
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy ended early");
  property p_accept;
    @(posedge clk) disable iff (!rst_b) $rose(mirror_scan) |-> frame_busy && !mirror_park;
  endproperty
  a_accept: assert property (p_accept) else $error("frame start");
  property p_rt_len;
    @(posedge clk) disable iff (!rst_b) $fell(rt_pulse) |-> rt_len >= 8'h64;
  endproperty
  a_rt_len: assert property (p_rt_len) else $error("rt width");
  property p_rt_cause;
    @(posedge clk) disable iff (!rst_b) s_therm |-> s_rt_ans;
  endproperty
  a_rt_cause: assert property (p_rt_cause) else $error("rt missing");
  property p_ser_half;
    @(posedge link_clk) disable iff (!rst_b) clk_seen && ser_clk != last_clk |-> half_len == 10'h340;
  endproperty
  a_ser_half: assert property (p_ser_half) else $error("ser clk rate");
  property p_ser_idle;
    @(posedge link_clk) disable iff (!rst_b) !ser_word_active |-> !ser_data;
  endproperty
  a_ser_idle: assert property (p_ser_idle) else $error("data idle level");
endmodule : frame_seq_checker

bind interferogram_frame_sequencer frame_seq_checker #(.COLLECT_CYC(COLLECT_CYC)) u_frame_seq_checker (
  .clk, .rst_b, .link_clk, .thermal_evt, .eof_pulse, .rt_pulse, .ser_clk, .ser_data,
  .ser_word_active, .mirror_park, .mirror_scan, .frame_busy
);

//--- tb/spacecraft_model.sv
`timescale 1ns/100ps
module spacecraft_model #(
  parameter logic [15:0] INIT_CYC = 16'h4e20,
  parameter logic [15:0] TICK_CYC = 16'h61a8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic fire,
  output logic frame_init,
  output logic tick400,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_word_active,
  output frame_seq_pkg::data_word_t rx_word,
  output logic [15:0] rx_cnt = 16'h0
);
  import frame_seq_pkg::*;
  logic [15:0] init_left;
  logic [15:0] tick_cnt;
  logic armed = 1'b0;
  logic [3:0] nbits = 4'h0;
  data_word_t shift = 10'h0;
  // each command becomes one fixed-length initiate unless one is still running, when it is ignored; pacing is the bench's job
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      init_left <= 16'h0;
      tick_cnt <= 16'h0;
    end else begin
      if (fire && init_left == 16'h0) init_left <= INIT_CYC;
      else if (init_left != 16'h0) init_left <= init_left - 16'h1;
      tick_cnt <= (tick_cnt == TICK_CYC - 16'h1) ? 16'h0 : tick_cnt + 16'h1;
    end
  end
  assign frame_init = init_left != 16'h0;
  assign tick400 = rst_b && tick_cnt == 16'h0;
  // armed only after a falling edge inside a word, so a load mid-cell adds no bit
  always @(negedge ser_clk) begin
    #1 armed = ser_word_active;
  end
  // bits taken mid-cell on the rising edge, msb first, high means one
  always @(posedge ser_clk) begin
    if (armed) begin
      shift = {shift[8:0], ser_data};
      nbits = nbits + 4'h1;
    end
    if (nbits == 4'ha) begin
      rx_word = shift;
      rx_cnt = rx_cnt + 16'h1;
      nbits = 4'h0;
    end
  end
endmodule : spacecraft_model

//--- tb/interferogram_frame_sequencer_tb.sv
`timescale 1ns/100ps
`include "frame_seq_params.svh"
module interferogram_frame_sequencer_tb;
  import frame_seq_pkg::*;
  // collection shortened so the collection window fits the run
  localparam logic [26:0] COLLECT = 27'h7d0;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_b = 1'b0;
  logic fire = 1'b0;
  logic fringe = 1'b0;
  logic thermal_evt = 1'b0;
  data_word_t sample_word = 10'h2b5;
  data_word_t hk_word = 10'h0;
  data_word_t rx_word;
  logic [15:0] rx_cnt;
  logic [4:0] hk_sel;
  logic frame_init, tick400, eof_pulse, rt_pulse, ser_clk, ser_data, ser_word_active;
  logic mirror_park, mirror_scan, frame_busy, overrun;
  int num_errors = 0;
  int n_checks = 0;

  interferogram_frame_sequencer #(.COLLECT_CYC(COLLECT)) u_interferogram_frame_sequencer (
    .clk, .rst_b, .link_clk, .frame_init, .fringe, .tick400, .thermal_evt, .sample_word,
    .hk_word, .hk_sel, .eof_pulse, .rt_pulse, .ser_clk, .ser_data, .ser_word_active,
    .mirror_park, .mirror_scan, .frame_busy, .overrun
  );
  // initiate length and tick spacing shortened to keep the run brief
  spacecraft_model #(.INIT_CYC(16'hc8), .TICK_CYC(16'h32)) u_spacecraft_model (
    .clk, .rst_b, .fire, .frame_init, .tick400, .ser_clk, .ser_data, .ser_word_active,
    .rx_word, .rx_cnt
  );

  initial begin
    forever #50 clk = ~clk;
  end
  // link clock offset so its edges drift against the core clock
  initial begin
    #3.3;
    forever #6 link_clk = ~link_clk;
  end
  // housekeeping source answers whatever index is selected
  always @(posedge clk) begin
    hk_word <= {5'h0, hk_sel};
  end

  task automatic check(input logic [26:0] seen, input logic [26:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      num_errors++;
      complete_run();
    end
  endtask : guard

  task automatic t_realtime;
    int n;
    @(posedge clk) thermal_evt <= 1'b1;
    repeat (3) @(posedge clk);
    thermal_evt <= 1'b0;
    n = 0;
    while (rt_pulse !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    guard(n, 20);
    n = 0;
    while (rt_pulse === 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    check(n, 27'(`RT_PULSE_CYC));
  endtask : t_realtime

  // a second initiate mid-collection must not restart or stretch the frame
  task automatic t_frame;
    int n;
    @(posedge clk) fire <= 1'b1;
    @(posedge clk) fire <= 1'b0;
    n = 0;
    while (mirror_scan !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    guard(n, 300);
    check({mirror_park, frame_busy, overrun}, 3'b010);
    fork
      for (int i = 0; i < 400; i++) begin
        @(posedge clk);
        fringe <= i[2];
        fire <= (i == 300);
      end
      begin
        n = 0;
        while (mirror_scan === 1'b1 && n < 3000) begin
          @(negedge clk);
          n++;
        end
      end
    join
    check(n, COLLECT);
    check({mirror_park, frame_busy, overrun}, 3'b111);
    check(hk_sel, 27'h0);
  endtask : t_frame

  task automatic t_serial;
    int n;
    for (int k = 1; k <= 2; k++) begin
      n = 0;
      while (rx_cnt < k && n < 12000) begin
        @(negedge clk);
        n++;
      end
      guard(n, 12000);
      check(rx_word, 10'h2b5);
    end
  endtask : t_serial

  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    check({mirror_park, mirror_scan, frame_busy, eof_pulse}, 4'h8);
    t_realtime();
    t_frame();
    t_serial();
    complete_run();
  end
endmodule : interferogram_frame_sequencer_tb
